// ### rtl/ycse_consts.vh
/*
 * constants for the yuv capture control and status bank: register indexes,
 * field positions, reset values and fill thresholds.
 * assumes it is included by the bank module, the checks and the bench, by its bare name.
 */
`ifndef YCSE_CONSTS_VH
`define YCSE_CONSTS_VH

////////////////////////////////////////////////////////////////////////////////
// register indexes; byte address is four times the index
`define YCSE_IDX_CTRL 16'h2800
`define YCSE_IDX_STATUS 16'h2802
`define YCSE_IDX_IRQ_EN 16'h2806
`define YCSE_IDX_TRIG 16'h2820
`define YCSE_IDX_FIFO_SIZE 16'h2824
`define YCSE_IDX_IRQ_STAT 16'h2830
`define YCSE_IDX_IRQ_CLR 16'h2832

////////////////////////////////////////////////////////////////////////////////
// control register fields
`define YCSE_CTRL_EN 0
`define YCSE_CTRL_FLOW_LO 1
`define YCSE_CTRL_FLOW_HI 3
`define YCSE_CTRL_SRST 15

// data flow modes
`define YCSE_FLOW_MEM422 3'h1
`define YCSE_FLOW_CAM422 3'h3
`define YCSE_FLOW_CAM420 3'h7

////////////////////////////////////////////////////////////////////////////////
// status register fields
`define YCSE_ST_EMPTY 8
`define YCSE_ST_FULL 9
`define YCSE_ST_TRIG 10
`define YCSE_ST_FLAG_LO 8
`define YCSE_ST_FLAG_HI 10
`define YCSE_ST_FILL_LO 12
`define YCSE_ST_FILL_HI 13
`define YCSE_ST_RSV_HI 2'h2
`define YCSE_ST_RSV_MID 1'h0
`define YCSE_ST_RSV_LO 8'h80
`define YCSE_STATUS_RESET 16'h8080

// trigger threshold field
`define YCSE_TRIG_LO 4
`define YCSE_TRIG_HI 5

// fifo size field, in dwords
`define YCSE_SIZE_W 12
`define YCSE_SIZE_RESET 12'h040

// fill codes and the dword floor of code 01
`define YCSE_FILL_EMPTY 2'h0
`define YCSE_FILL_LOW 2'h1
`define YCSE_FILL_QUARTER 2'h2
`define YCSE_FILL_HALF 2'h3
`define YCSE_MIN_DWORDS 13'h0003
`define YCSE_OUT_MIN 6'h03

`endif

// ### rtl/ycse_bank.v
/*
 * yuv capture control and status register bank behind an apb slave.
 * assumes the capture fifo datapath supplies fill counts and full levels
 * synchronous to pclk, and consumes the enable, clock gate and flow outputs.
 */
// Chosen here: the APB interface to the registers.
// Operation
// [RL1] software must keep the converter bypass bit clear while memory-to-memory 4:2:2 flow is chosen.
// [RL2] software must program a resizer width that is a multiple of four before a 4:2:0 capture.
// [RL3] enable bit clear holds the unit disabled with its clock gated, set enables it and supplies clock.
// [RL4] a read-only two-bit fill level reports empty, three dwords, a quarter or half of the fifo size.
// [RL5] the trigger flag latches once the fill reaches the programmed threshold, otherwise it stays zero.
// [RL6] each flag is set and visible only while its own interrupt enable bit is set; here a flag already set stays readable after its enable clears.
// [RL7] each flag stays set until software writes one to its bit, which then clears it.
// [RL8] the full flag sets only when capture fifo and capture input fifo are full together.
// [RL9] the empty flag sets while the output fifo holds fewer than three dwords.
// [RL10] reserved status fields read 10b on top, 0b at bit eleven and 1000_0000b in the low byte.
// [RL11] the self-clearing software reset reinitialises the status register but keeps the three flags.
// [RL12] flow mode 111b means 4:2:0 data from the camera interface written to memory.
// [RL13] writes of zero to flags and writes to read-only or reserved status fields are ignored.
`include "ycse_consts.vh"

module ycse_bank (
   pclk,
   presetn,
   psel,
   penable,
   pwrite,
   paddr,
   pwdata,
   pstrb,
   prdata,
   pready,
   pslverr,
   cap_fifo_level,
   out_fifo_level,
   cap_fifo_full,
   cap_in_fifo_full,
   cap_enable,
   cap_clk_en,
   cap_soft_rst,
   flow_mem422,
   flow_cam422,
   flow_cam420,
   irq
);
   input wire pclk;
   input wire presetn;
   input wire psel;
   input wire penable;
   input wire pwrite;
   input wire [17:0] paddr;
   input wire [31:0] pwdata;
   input wire [3:0] pstrb;
   output reg [31:0] prdata;
   output reg pready;
   output reg pslverr;
   input wire [11:0] cap_fifo_level;
   input wire [5:0] out_fifo_level;
   input wire cap_fifo_full;
   input wire cap_in_fifo_full;
   output reg cap_enable;
   output reg cap_clk_en;
   output reg cap_soft_rst;
   output reg flow_mem422;
   output reg flow_cam422;
   output reg flow_cam420;
   output reg irq;

   ////////////////////////////////////////////////////////////////////////////
   // fill code from the live counts; used for the status field and trigger
   function [1:0] fill_code;
      input [11:0] cap_lvl;
      input [5:0] out_lvl;
      input [11:0] size;
      reg [12:0] total;
      begin
         total = {1'b0, cap_lvl} + {7'h00, out_lvl};
         if (cap_lvl >= {1'b0, size[11:1]} && cap_lvl != 12'h000) begin
            fill_code = `YCSE_FILL_HALF;
         end else if (cap_lvl >= {2'h0, size[11:2]} && cap_lvl != 12'h000) begin
            fill_code = `YCSE_FILL_QUARTER;
         end else if (total >= `YCSE_MIN_DWORDS) begin
            fill_code = `YCSE_FILL_LOW;
         end else begin
            fill_code = `YCSE_FILL_EMPTY;
         end
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // state
   reg enable_ff;
   reg [2:0] flow_ff;
   reg srst_ff;
   reg [2:0] flags_ff;
   reg [1:0] fill_ff;
   reg [2:0] irq_en_ff;
   reg [1:0] trig_ff;
   reg [11:0] size_ff;
   reg [31:0] nxt_prdata;
   reg nxt_slverr;
   reg [2:0] nxt_flags;
   reg [2:0] flag_event;
   reg [2:0] flag_clear;
   reg [15:0] wmask;
   reg [15:0] wdat;
   reg [1:0] live_fill;
   reg trig_hit;
   wire setup;
   wire wr_go;
   wire [15:0] idx;
   wire [15:0] status_word;

   assign idx = paddr[17:2];
   assign setup = psel & ~penable & ~pready;
   assign wr_go = psel & penable & pready & pwrite;

   // reserved fields are constants, never stored
   assign status_word = {`YCSE_ST_RSV_HI, fill_ff, `YCSE_ST_RSV_MID, flags_ff, `YCSE_ST_RSV_LO}; // see [RL10] [RL4]

   ////////////////////////////////////////////////////////////////////////////
   // flag events and clears
   always @* begin
      wmask = {{8{pstrb[1]}}, {8{pstrb[0]}}};
      wdat = pwdata[15:0] & wmask;
      live_fill = fill_code(cap_fifo_level, out_fifo_level, size_ff);
      if (trig_ff == `YCSE_FILL_EMPTY) begin
         trig_hit = (cap_fifo_level != 12'h000); // see [RL5]
      end else begin
         trig_hit = (live_fill >= trig_ff); // see [RL5]
      end
      flag_event[2] = trig_hit;
      flag_event[1] = cap_fifo_full & cap_in_fifo_full; // see [RL8]
      flag_event[0] = (out_fifo_level < `YCSE_OUT_MIN); // see [RL9]
      flag_event = flag_event & irq_en_ff; // see [RL6]
      flag_clear = 3'h0;
      if (wr_go && (idx == `YCSE_IDX_STATUS || idx == `YCSE_IDX_IRQ_CLR)) begin
         flag_clear = wdat[`YCSE_ST_FLAG_HI:`YCSE_ST_FLAG_LO]; // see [RL7] [RL13]
      end
      // a new event in the clearing cycle wins so it is never lost
      nxt_flags = (flags_ff & ~flag_clear) | flag_event; // see [RL7]
   end

   ////////////////////////////////////////////////////////////////////////////
   // read mux, sampled in the setup cycle
   always @* begin
      nxt_prdata = 32'h00000000;
      nxt_slverr = 1'b0;
      case (idx)
         `YCSE_IDX_CTRL: begin
            nxt_prdata[`YCSE_CTRL_EN] = enable_ff;
            nxt_prdata[`YCSE_CTRL_FLOW_HI:`YCSE_CTRL_FLOW_LO] = flow_ff;
         end
         `YCSE_IDX_STATUS: begin
            nxt_prdata[15:0] = status_word;
         end
         `YCSE_IDX_IRQ_EN: begin
            nxt_prdata[`YCSE_ST_FLAG_HI:`YCSE_ST_FLAG_LO] = irq_en_ff;
         end
         `YCSE_IDX_TRIG: begin
            nxt_prdata[`YCSE_TRIG_HI:`YCSE_TRIG_LO] = trig_ff;
         end
         `YCSE_IDX_FIFO_SIZE: begin
            nxt_prdata[`YCSE_SIZE_W-1:0] = size_ff;
         end
         `YCSE_IDX_IRQ_STAT: begin
            nxt_prdata[`YCSE_ST_FLAG_HI:`YCSE_ST_FLAG_LO] = flags_ff;
         end
         `YCSE_IDX_IRQ_CLR: begin
            nxt_prdata = 32'h00000000;
         end
         default: begin
            nxt_slverr = 1'b1;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // apb handshake: pready rises in the first access cycle
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         prdata <= 32'h00000000;
         pslverr <= 1'b0;
      end else begin
         pready <= setup;
         if (setup) begin
            prdata <= pwrite ? 32'h00000000 : nxt_prdata;
            pslverr <= nxt_slverr;
         end else if (pready) begin
            prdata <= 32'h00000000;
            pslverr <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // software registers
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         enable_ff <= 1'b0;
         flow_ff <= 3'h0;
         srst_ff <= 1'b0;
         irq_en_ff <= 3'h0;
         trig_ff <= 2'h0;
         size_ff <= `YCSE_SIZE_RESET;
      end else begin
         srst_ff <= 1'b0; // self clearing after one cycle
         if (wr_go) begin
            case (idx)
               `YCSE_IDX_CTRL: begin
                  if (pstrb[0]) begin
                     enable_ff <= pwdata[`YCSE_CTRL_EN];
                     flow_ff <= pwdata[`YCSE_CTRL_FLOW_HI:`YCSE_CTRL_FLOW_LO];
                  end
                  if (pstrb[1]) begin
                     srst_ff <= pwdata[`YCSE_CTRL_SRST]; // see [RL11]
                  end
               end
               `YCSE_IDX_IRQ_EN: begin
                  if (pstrb[1]) begin
                     irq_en_ff <= pwdata[`YCSE_ST_FLAG_HI:`YCSE_ST_FLAG_LO];
                  end
               end
               `YCSE_IDX_TRIG: begin
                  if (pstrb[0]) begin
                     trig_ff <= pwdata[`YCSE_TRIG_HI:`YCSE_TRIG_LO];
                  end
               end
               `YCSE_IDX_FIFO_SIZE: begin
                  if (pstrb[0]) begin
                     size_ff[7:0] <= pwdata[7:0];
                  end
                  if (pstrb[1]) begin
                     size_ff[11:8] <= pwdata[11:8];
                  end
               end
               default: begin
                  enable_ff <= enable_ff;
               end
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // status: flags survive the soft reset, the fill field does not
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flags_ff <= 3'h0;
         fill_ff <= `YCSE_FILL_EMPTY;
      end else begin
         flags_ff <= nxt_flags;
         if (srst_ff) begin
            fill_ff <= `YCSE_FILL_EMPTY; // see [RL11]
         end else begin
            fill_ff <= live_fill; // see [RL4]
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // unit outputs, all registered
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cap_enable <= 1'b0;
         cap_clk_en <= 1'b0;
         cap_soft_rst <= 1'b0;
         flow_mem422 <= 1'b0;
         flow_cam422 <= 1'b0;
         flow_cam420 <= 1'b0;
         irq <= 1'b0;
      end else begin
         cap_enable <= enable_ff; // see [RL3]
         cap_clk_en <= enable_ff; // see [RL3]
         cap_soft_rst <= srst_ff;
         // reserved modes decode to no flow; software keeps the bypass bit clear in 001b, see [RL1]
         flow_mem422 <= (flow_ff == `YCSE_FLOW_MEM422);
         flow_cam422 <= (flow_ff == `YCSE_FLOW_CAM422);
         // width multiple of four is software's duty, see [RL2]
         flow_cam420 <= (flow_ff == `YCSE_FLOW_CAM420); // see [RL12]
         irq <= |(nxt_flags & irq_en_ff); // see [RL6]
      end
   end

endmodule

// ### verif/ycse_bank_props.sv
/* concurrent checks on the ports of the yuv capture status bank.
   assumes a single pclk domain with presetn active low. */
`include "ycse_consts.vh"
module ycse_bank_props (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [17:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [11:0] cap_fifo_level,
   input wire logic [5:0] out_fifo_level,
   input wire logic cap_enable,
   input wire logic cap_clk_en,
   input wire logic cap_soft_rst,
   input wire logic flow_mem422,
   input wire logic flow_cam422,
   input wire logic flow_cam420,
   input wire logic irq
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   ////////////////////////////////////////////////////////////////////////////
   wire acc = psel && penable && pready;
   wire wctl = acc && pwrite && paddr[17:2] == `YCSE_IDX_CTRL;
   wire rst_rd = acc && !pwrite && paddr[17:2] == `YCSE_IDX_STATUS;
   // a write of the enable bit with its lane on turns enable and clock gate on within two cycles
   property p_en;
      wctl && pstrb[0] && pwdata[0] |-> ##[1:2] (cap_enable && cap_clk_en);
   endproperty
   a_en: assert property (p_en) else $error("enable write not applied");
   property p_flow;
      wctl && pstrb[0] && pwdata[3:1] == `YCSE_FLOW_CAM420 |-> ##[1:2] (flow_cam420 && !flow_mem422 && !flow_cam422);
   endproperty
   a_flow: assert property (p_flow) else $error("flow 111 decode wrong");
   property p_rsv;
      rst_rd |-> prdata[31:16] == 16'h0000 && prdata[15:14] == 2'h2 && !prdata[11] && prdata[7:0] == 8'h80;
   endproperty
   a_rsv: assert property (p_rsv) else $error("reserved status bits wrong");
   property p_fill;
      (cap_fifo_level == 12'h000 && out_fifo_level == 6'h00) [*3] ##0 rst_rd |-> prdata[13:12] == 2'h0;
   endproperty
   a_fill: assert property (p_fill) else $error("fill code not empty");
   property p_srst;
      wctl && pstrb[1] && pwdata[15] |-> ##[1:2] cap_soft_rst;
   endproperty
   a_srst: assert property (p_srst) else $error("soft reset pulse missing");
   property p_pulse;
      cap_soft_rst |=> !cap_soft_rst;
   endproperty
   a_pulse: assert property (p_pulse) else $error("soft reset pulse too long");
   // flags only drop by software action, so irq may fall only after a write
   property p_irq;
      $fell(irq) |-> $past(acc && pwrite) || $past(acc && pwrite, 2) || $past(acc && pwrite, 3);
   endproperty
   a_irq: assert property (p_irq) else $error("irq fell without a write");
   property p_err;
      pslverr |-> pready && prdata == 32'h0000_0000;
   endproperty
   a_err: assert property (p_err) else $error("error response carries data");
endmodule
////////////////////////////////////////////////////////////////////////////////
bind ycse_bank ycse_bank_props u_props (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
   .pslverr(pslverr),
   .cap_fifo_level(cap_fifo_level), .out_fifo_level(out_fifo_level), .cap_enable(cap_enable),
   .cap_clk_en(cap_clk_en), .cap_soft_rst(cap_soft_rst), .flow_mem422(flow_mem422),
   .flow_cam422(flow_cam422), .flow_cam420(flow_cam420), .irq(irq));

// ### verif/ycse_bank_tb.sv
/* self-checking bench for the yuv capture status bank over apb.
   assumes the bank answers each access within a few cycles. */
`include "ycse_consts.vh"
`define CHK(g,e) begin comparisons++; if ((g)!==(e)) begin miscompares++; $display("ERROR t=%0t %h %h",$time,g,e); end end
module ycse_bank_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, cif = 0, cin = 0, err;
   logic [17:0] paddr = 0;
   logic [31:0] pwdata = 0, rd;
   logic [11:0] cap = 0;
   logic [5:0] outl = 0;
   wire [31:0] prdata;
   wire pready, pslverr, en, ce, srst, fm1, fm3, fm7, irq;
   int miscompares = 0, comparisons = 0, nsrst = 0;
   always #10 pclk = ~pclk;
   always @(posedge pclk) if (srst === 1'b1) nsrst++;
   ycse_bank DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready), .pslverr(pslverr), .cap_fifo_level(cap),
      .out_fifo_level(outl), .cap_fifo_full(cif), .cap_in_fifo_full(cin), .cap_enable(en), .cap_clk_en(ce),
      .cap_soft_rst(srst), .flow_mem422(fm1), .flow_cam422(fm3), .flow_cam420(fm7), .irq(irq));
   ////////////////////////////////////////////////////////////////////////////
   task automatic tally_and_finish;
      $display("miscompares %0d comparisons %0d", miscompares, comparisons);
      if (miscompares == 0 && comparisons > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // request held until pready is seen at an edge; data taken there
   task automatic apb(input logic w, input logic [15:0] idx, input logic [15:0] d);
      int n = 0;
      @(posedge pclk);
      psel <= 1;
      penable <= 0;
      pwrite <= w;
      paddr <= {idx, 2'h0};
      pwdata <= {16'h0000, d};
      @(posedge pclk);
      penable <= 1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 8);
      if (pready !== 1'b1) begin
         miscompares++;
         tally_and_finish;
      end
      rd = prdata;
      err = pslverr;
      psel <= 0;
      penable <= 0;
   endtask
   task automatic rdchk(input logic [15:0] idx, input logic [31:0] e);
      apb(0, idx, 16'h0000);
      `CHK(rd, e)
   endtask
   // outputs are registered copies, so allow two edges
   task automatic settle;
      repeat (2) @(posedge pclk);
      #1;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   task automatic t_ctrl;
      `CHK({en, ce, irq}, 3'h0)
      rdchk(`YCSE_IDX_STATUS, 32'h0000_8080);
      for (int f = 0; f < 8; f++) begin
         // converter bypass bit and resizer width live outside this bank and stay legal here
         apb(1, `YCSE_IDX_CTRL, 16'(2 * f + 1));
         settle;
         `CHK({en, ce, fm1, fm3, fm7}, {2'h3, f == 1, f == 3, f == 7})
      end
      apb(1, `YCSE_IDX_CTRL, 16'h0000);
      settle;
      `CHK({en, ce}, 2'h0)
   endtask
   // interrupt enables still clear: empty condition holds but stays masked
   task automatic t_fill;
      int c[7] = '{0, 1, 2, 15, 16, 31, 32};
      int o[7] = '{0, 2, 0, 0, 0, 0, 0};
      logic [1:0] e[7] = '{0, 1, 0, 1, 2, 2, 3};
      for (int i = 0; i < 7; i++) begin
         cap <= 12'(c[i]);
         outl <= 6'(o[i]);
         rdchk(`YCSE_IDX_STATUS, {16'h0000, 2'h2, e[i], 12'h080});
      end
   endtask
   task automatic t_flags;
      cap <= 12'h000;
      outl <= 6'h03;
      apb(1, `YCSE_IDX_TRIG, 16'h0020);
      apb(1, `YCSE_IDX_IRQ_EN, 16'h0700);
      rdchk(`YCSE_IDX_STATUS, 32'h0000_9080);
      outl <= 6'h00;
      rdchk(`YCSE_IDX_STATUS, 32'h0000_8180);
      `CHK(irq, 1'b1)
      apb(1, `YCSE_IDX_STATUS, 16'hF8FF);
      rdchk(`YCSE_IDX_STATUS, 32'h0000_8180);
      outl <= 6'h03;
      apb(1, `YCSE_IDX_STATUS, 16'h0100);
      rdchk(`YCSE_IDX_STATUS, 32'h0000_9080);
      `CHK(irq, 1'b0)
      cif <= 1;
      rdchk(`YCSE_IDX_STATUS, 32'h0000_9080);
      cin <= 1;
      rdchk(`YCSE_IDX_STATUS, 32'h0000_9280);
      cif <= 0;
      cin <= 0;
      apb(1, `YCSE_IDX_IRQ_CLR, 16'h0200);
      rdchk(`YCSE_IDX_STATUS, 32'h0000_9080);
      cap <= 12'h010;
      rdchk(`YCSE_IDX_STATUS, 32'h0000_A480);
   endtask
   // the read right after the soft reset sees the fill field cleared, the trigger flag kept
   task automatic t_srst;
      cap <= 12'h000;
      apb(1, `YCSE_IDX_CTRL, 16'h8000);
      rdchk(`YCSE_IDX_STATUS, 32'h0000_8480);
      `CHK(nsrst, 1)
      rdchk(`YCSE_IDX_CTRL, 32'h0000_0000);
      rdchk(`YCSE_IDX_IRQ_STAT, 32'h0000_0400);
      apb(1, `YCSE_IDX_STATUS, 16'h0400);
      rdchk(`YCSE_IDX_STATUS, 32'h0000_9080);
   endtask
   task automatic t_bad;
      apb(1, 16'h0000, 16'hFFFF);
      `CHK(err, 1'b1)
      rdchk(16'h0001, 32'h0000_0000);
      `CHK(err, 1'b1)
      rdchk(`YCSE_IDX_STATUS, 32'h0000_9080);
   endtask
   // threshold 00 and 11, and a small fifo size so the quarter and half marks are near
   task automatic t_trig;
      apb(1, `YCSE_IDX_TRIG, 16'h0000);
      cap <= 12'h001;
      rdchk(`YCSE_IDX_STATUS, 32'h0000_9480);
      apb(1, `YCSE_IDX_TRIG, 16'h0030);
      apb(1, `YCSE_IDX_FIFO_SIZE, 16'h0008);
      rdchk(`YCSE_IDX_FIFO_SIZE, 32'h0000_0008);
      apb(1, `YCSE_IDX_STATUS, 16'h0400);
      cap <= 12'h002;
      rdchk(`YCSE_IDX_STATUS, 32'h0000_A080);
      cap <= 12'h004;
      rdchk(`YCSE_IDX_STATUS, 32'h0000_B480);
      `CHK(irq, 1'b1)
      rdchk(`YCSE_IDX_IRQ_EN, 32'h0000_0700);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (4) @(posedge pclk);
      presetn <= 1;
      t_ctrl;
      t_fill;
      t_flags;
      t_srst;
      t_bad;
      t_trig;
      tally_and_finish;
   end
endmodule
